/* File: pkg/irs_pkg.sv */
`default_nettype none
package irs_pkg;
  // Width of the I/O address and of every register.
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DEPTH  = 64;

  // Register offsets in the I/O space.
  localparam logic [5:0] ADC_CONTROL_STATUS_B         = 6'h03;
  localparam logic [5:0] ADC_RESULT_LOW_BYTE          = 6'h04;
  localparam logic [5:0] ADC_RESULT_HIGH_BYTE         = 6'h05;
  localparam logic [5:0] ADC_CONTROL_STATUS_A         = 6'h06;
  localparam logic [5:0] ADC_CHANNEL_REFERENCE_SELECT = 6'h07;
  localparam logic [5:0] ANALOG_COMPARATOR_CTRL_STAT  = 6'h08;
  localparam logic [5:0] SERIAL_IFACE_CONTROL         = 6'h0D;
  localparam logic [5:0] SERIAL_IFACE_STATUS          = 6'h0E;
  localparam logic [5:0] SERIAL_IFACE_SHIFT_DATA      = 6'h0F;
  localparam logic [5:0] SERIAL_IFACE_BUFFERED_DATA   = 6'h10;
  localparam logic [5:0] GENERAL_SCRATCH_0            = 6'h11;
  localparam logic [5:0] GENERAL_SCRATCH_1            = 6'h12;
  localparam logic [5:0] GENERAL_SCRATCH_2            = 6'h13;
  localparam logic [5:0] DIGITAL_INPUT_DISABLE        = 6'h14;
  localparam logic [5:0] PIN_CHANGE_MASK              = 6'h15;
  localparam logic [5:0] PORT_PIN_INPUT_LEVELS        = 6'h16;
  localparam logic [5:0] PORT_DIRECTION               = 6'h17;
  localparam logic [5:0] PORT_OUTPUT_DATA             = 6'h18;
  localparam logic [5:0] EEPROM_ADDRESS_HIGH          = 6'h1D;
  localparam logic [5:0] EEPROM_CONTROL               = 6'h1C;
  localparam logic [5:0] EEPROM_DATA                  = 6'h1E;
  localparam logic [5:0] EEPROM_ADDRESS_LOW           = 6'h1F;
  localparam logic [5:0] POWER_REDUCTION              = 6'h20;
  localparam logic [5:0] WATCHDOG_CONTROL             = 6'h21;
  localparam logic [5:0] DEBUG_WIRE_DATA              = 6'h22;
  localparam logic [5:0] DEAD_TIME_PRESCALE           = 6'h23;
  localparam logic [5:0] DEAD_TIME_CHANNEL_B          = 6'h24;
  localparam logic [5:0] DEAD_TIME_CHANNEL_A          = 6'h25;
  localparam logic [5:0] CLOCK_PRESCALE               = 6'h26;
  localparam logic [5:0] PLL_CONTROL_STATUS           = 6'h27;
  localparam logic [5:0] TIMER0_COMPARE_B             = 6'h28;

  // Highest address that the single-bit instructions may reach.
  localparam logic [5:0] BIT_ACCESS_TOP = 6'h1F;

  // Reset value of every stored register.
  localparam logic [7:0] REG_RESET = 8'h00;

  // Bit positions of the read-only status levels, and the number of port pins.
  localparam int unsigned COMP_OUT_BIT  = 5;
  localparam int unsigned SER_COUNT_BIT = 4;
  localparam int unsigned PLL_LOCK_BIT  = 0;
  localparam int unsigned PIN_W         = 6;

  // Write-one-to-clear flags: count, home register and bit of each.
  localparam int unsigned NFLAGS = 6;
  localparam logic [5:0] FLAG_ADDR [NFLAGS] = '{ADC_CONTROL_STATUS_A, ANALOG_COMPARATOR_CTRL_STAT,
    SERIAL_IFACE_STATUS, SERIAL_IFACE_STATUS, SERIAL_IFACE_STATUS, WATCHDOG_CONTROL};
  localparam logic [2:0] FLAG_BIT [NFLAGS] = '{3'h4, 3'h4, 3'h7, 3'h6, 3'h5, 3'h7};

  // Bits that software may store at each address; zero for reserved
  // bits, read-only bits, flags and reserved or foreign addresses.
  function automatic logic [7:0] rw_mask(input logic [5:0] a);
    case (a)
      ADC_CONTROL_STATUS_B:         rw_mask = 8'hE7;
      ADC_CONTROL_STATUS_A:         rw_mask = 8'hEF;
      ADC_CHANNEL_REFERENCE_SELECT: rw_mask = 8'hFF;
      ANALOG_COMPARATOR_CTRL_STAT:  rw_mask = 8'hCB;
      SERIAL_IFACE_CONTROL:         rw_mask = 8'hFF;
      SERIAL_IFACE_STATUS:          rw_mask = 8'h0F;
      SERIAL_IFACE_SHIFT_DATA:      rw_mask = 8'hFF;
      GENERAL_SCRATCH_0:            rw_mask = 8'hFF;
      GENERAL_SCRATCH_1:            rw_mask = 8'hFF;
      GENERAL_SCRATCH_2:            rw_mask = 8'hFF;
      DIGITAL_INPUT_DISABLE:        rw_mask = 8'h3F;
      PIN_CHANGE_MASK:              rw_mask = 8'h3F;
      PORT_DIRECTION:               rw_mask = 8'h3F;
      PORT_OUTPUT_DATA:             rw_mask = 8'h3F;
      EEPROM_CONTROL:               rw_mask = 8'h3F;
      EEPROM_ADDRESS_HIGH:          rw_mask = 8'h01;
      EEPROM_DATA:                  rw_mask = 8'hFF;
      EEPROM_ADDRESS_LOW:           rw_mask = 8'hFF;
      POWER_REDUCTION:              rw_mask = 8'h0F;
      WATCHDOG_CONTROL:             rw_mask = 8'h7F;
      DEBUG_WIRE_DATA:              rw_mask = 8'hFF;
      DEAD_TIME_PRESCALE:           rw_mask = 8'h03;
      DEAD_TIME_CHANNEL_B:          rw_mask = 8'hFF;
      DEAD_TIME_CHANNEL_A:          rw_mask = 8'hFF;
      CLOCK_PRESCALE:               rw_mask = 8'h8F;
      PLL_CONTROL_STATUS:           rw_mask = 8'h86;
      TIMER0_COMPARE_B:             rw_mask = 8'hFF;
      default:                      rw_mask = 8'h00;
    endcase
  endfunction : rw_mask

  // Kind of access taken in one cycle.
  typedef enum logic [2:0] {ACC_NONE, ACC_WRITE, ACC_SET, ACC_CLR, ACC_READ, ACC_TEST1, ACC_TEST0} irs_acc_t;
endpackage : irs_pkg
`default_nettype wire

/* File: src/irs_store.sv */
`timescale 1ns/1ps
`default_nettype none
// Register storage with a per-bit write enable and a registered read port.
module irs_store (
  input  wire logic                       sys_clk,
  input  wire logic                       resetn,
  input  wire logic [irs_pkg::ADDR_W-1:0] wrAddr,
  input  wire logic [irs_pkg::DATA_W-1:0] wrBitEn,
  input  wire logic [irs_pkg::DATA_W-1:0] wrData,
  input  wire logic [irs_pkg::ADDR_W-1:0] rdAddr,
  output var  logic [irs_pkg::DATA_W-1:0] rdData_r
);
  // One byte per address; reserved entries never get a write enable.
  logic [irs_pkg::DATA_W-1:0] mem [irs_pkg::DEPTH];

  // Each entry resets so that control state is defined after reset.
  for (genvar e = 0; e < irs_pkg::DEPTH; e++) begin : gEntry
    wire logic hit = (wrAddr == irs_pkg::ADDR_W'(e));
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        mem[e] <= irs_pkg::REG_RESET;
      end else if (hit) begin
        // Only enabled bits move; the rest of the byte is untouched.
        mem[e] <= (mem[e] & ~wrBitEn) | (wrData & wrBitEn);
      end
    end
  end

  // The read data leave through a register, one cycle after the address.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdData_r <= irs_pkg::REG_RESET;
    end else begin
      rdData_r <= mem[rdAddr];
    end
  end
endmodule : irs_store
`default_nettype wire

/* File: src/irs_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module irs_regs (
  input  wire logic                       sys_clk,
  input  wire logic                       resetn,
  input  wire logic [irs_pkg::ADDR_W-1:0] ioAddr,
  input  wire logic                       ioWrEn,
  input  wire logic                       ioRdEn,
  input  wire logic [irs_pkg::DATA_W-1:0] ioWrData,
  input  wire logic                       ioBitSetInstr,
  input  wire logic                       ioBitClearInstr,
  input  wire logic                       skipIfIoBitOne,
  input  wire logic                       skipIfIoBitZero,
  input  wire logic [2:0]                 bitSel,
  input  wire logic [irs_pkg::NFLAGS-1:0] flagSetPulse,
  input  wire logic [irs_pkg::DATA_W-1:0] adcResultLow,
  input  wire logic [irs_pkg::DATA_W-1:0] adcResultHigh,
  input  wire logic [irs_pkg::DATA_W-1:0] serialBufData,
  input  wire logic [irs_pkg::PIN_W-1:0]  pinLevels,
  input  wire logic                       compOutLevel,
  input  wire logic                       serialCountLevel,
  input  wire logic                       pllLockLevel,
  output var  logic [irs_pkg::DATA_W-1:0] ioRdData_r,
  output var  logic                       ioRdValid_r,
  output var  logic                       skipTaken_r,
  output var  logic [irs_pkg::PIN_W-1:0]  portOut_r,
  output var  logic [irs_pkg::PIN_W-1:0]  portDir_r,
  output var  logic [irs_pkg::NFLAGS-1:0] flagState_r
);
  // Access kind chosen this cycle; a full write outranks the others.
  irs_pkg::irs_acc_t acc;
  // True when the address lies in the bit-accessible low range.
  wire logic lowRange = (ioAddr <= irs_pkg::BIT_ACCESS_TOP);
  // One-hot image of the selected bit.
  wire logic [7:0] bitOne = 8'h01 << bitSel;

  // Requests are expected one at a time; the priority only settles clashes.
  // Bit instructions above the low range are dropped here.
  always_comb begin
    if (ioWrEn) begin
      acc = irs_pkg::ACC_WRITE;
    end else if (ioBitSetInstr && lowRange) begin
      acc = irs_pkg::ACC_SET;
    end else if (ioBitClearInstr && lowRange) begin
      acc = irs_pkg::ACC_CLR;
    end else if (ioRdEn) begin
      acc = irs_pkg::ACC_READ;
    end else if (skipIfIoBitOne && lowRange) begin
      acc = irs_pkg::ACC_TEST1;
    end else if (skipIfIoBitZero && lowRange) begin
      acc = irs_pkg::ACC_TEST0;
    end else begin
      acc = irs_pkg::ACC_NONE;
    end
  end

  // Every write is reduced to a byte and a mask of bits it touches.
  // A bit instruction carries only the selected bit in its mask.
  wire logic isWrite = (acc == irs_pkg::ACC_WRITE);
  wire logic isSet   = (acc == irs_pkg::ACC_SET);
  wire logic isClr   = (acc == irs_pkg::ACC_CLR);
  wire logic anyWr   = isWrite | isSet | isClr;
  wire logic [7:0] wrMask = isWrite ? 8'hFF : ((isSet | isClr) ? bitOne : 8'h00);
  wire logic [7:0] wrByte = isWrite ? ioWrData : (isSet ? bitOne : 8'h00);
  // Storable bits at this address; reserved bits and reserved or foreign
  // addresses give zero, so such writes change nothing.
  wire logic [7:0] rwMask = irs_pkg::rw_mask(ioAddr);
  wire logic [7:0] stEn   = anyWr ? (wrMask & rwMask) : 8'h00;

  // Shared register storage; reserved bits are never enabled, so they read zero.
  logic [7:0] memRd;
  irs_store uStore (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .wrAddr   (ioAddr),
    .wrBitEn  (stEn),
    .wrData   (wrByte),
    .rdAddr   (ioAddr),
    .rdData_r (memRd)
  );

  // Write-one-to-clear flags, one slice per flag.
  logic [irs_pkg::NFLAGS-1:0] flagClr;
  for (genvar f = 0; f < irs_pkg::NFLAGS; f++) begin : gFlag
    // A one written into the flag position clears it; a bit instruction on
    // a neighbour has no one there, so the flag is left alone.
    assign flagClr[f] = anyWr && (ioAddr == irs_pkg::FLAG_ADDR[f])
                        && wrMask[irs_pkg::FLAG_BIT[f]] && wrByte[irs_pkg::FLAG_BIT[f]];
    // A hardware event in the clearing cycle wins, so no event is lost.
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        flagState_r[f] <= 1'b0;
      end else if (flagSetPulse[f]) begin
        flagState_r[f] <= 1'b1;
      end else if (flagClr[f]) begin
        flagState_r[f] <= 1'b0;
      end
    end
  end

  // Flag bits that belong to the addressed register.
  logic [7:0] flagBits;
  always_comb begin
    flagBits = 8'h00;
    for (int i = 0; i < irs_pkg::NFLAGS; i++) begin
      if (ioAddr == irs_pkg::FLAG_ADDR[i]) begin
        flagBits[irs_pkg::FLAG_BIT[i]] = flagState_r[i];
      end
    end
  end

  // Bits not held in storage: inputs sampled as they stand this cycle.
  logic [7:0] liveBits;
  always_comb begin
    case (ioAddr)
      irs_pkg::ADC_RESULT_LOW_BYTE:         liveBits = adcResultLow;
      irs_pkg::ADC_RESULT_HIGH_BYTE:        liveBits = adcResultHigh;
      irs_pkg::SERIAL_IFACE_BUFFERED_DATA:  liveBits = serialBufData;
      irs_pkg::PORT_PIN_INPUT_LEVELS:       liveBits = {2'b00, pinLevels};
      irs_pkg::ANALOG_COMPARATOR_CTRL_STAT: liveBits = 8'(compOutLevel) << irs_pkg::COMP_OUT_BIT;
      irs_pkg::SERIAL_IFACE_STATUS:         liveBits = 8'(serialCountLevel) << irs_pkg::SER_COUNT_BIT;
      irs_pkg::PLL_CONTROL_STATUS:          liveBits = 8'(pllLockLevel) << irs_pkg::PLL_LOCK_BIT;
      default:                              liveBits = 8'h00;  // Reserved addresses read zero.
    endcase
  end

  // Stage one of the read path: it lines the non-stored bits up with the
  // storage read, which is registered. The cost is a two-cycle read.
  wire logic isRead = (acc == irs_pkg::ACC_READ);
  wire logic isTest = (acc == irs_pkg::ACC_TEST1) || (acc == irs_pkg::ACC_TEST0);
  logic       rdPend_r;
  logic       testPend_r;
  logic       testOne_r;
  logic [2:0] testSel_r;
  logic [7:0] sideBits_r;
  logic [7:0] memKeep_r;

  // Captures the request and the bits that do not come from storage.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdPend_r   <= 1'b0;
      testPend_r <= 1'b0;
      testOne_r  <= 1'b0;
      testSel_r  <= 3'h0;
      sideBits_r <= 8'h00;
      memKeep_r  <= 8'h00;
    end else begin
      rdPend_r   <= isRead;
      testPend_r <= isTest;
      testOne_r  <= (acc == irs_pkg::ACC_TEST1);
      testSel_r  <= bitSel;
      sideBits_r <= flagBits | liveBits;
      memKeep_r  <= rwMask;
    end
  end

  // The assembled register value as it was at the request.
  wire logic [7:0] regVal  = (memRd & memKeep_r) | sideBits_r;
  // Skip decision: the chosen bit compared with the wanted level.
  wire logic       testHit = (regVal[testSel_r] == testOne_r);

  // Stage two: the answer leaves through registers.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ioRdData_r  <= 8'h00;
      ioRdValid_r <= 1'b0;
      skipTaken_r <= 1'b0;
    end else begin
      ioRdValid_r <= rdPend_r | testPend_r;
      ioRdData_r  <= (rdPend_r | testPend_r) ? regVal : ioRdData_r;
      skipTaken_r <= testPend_r & testHit;
    end
  end

  // Copies of the port registers that drive the pins; they follow the same
  // masked writes as storage, so bit instructions touch one pin only.
  wire logic [5:0] portEn = (ioAddr == irs_pkg::PORT_OUTPUT_DATA) ? stEn[5:0] : 6'h00;
  wire logic [5:0] dirEn  = (ioAddr == irs_pkg::PORT_DIRECTION) ? stEn[5:0] : 6'h00;

  // Pin drive state.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      portOut_r <= 6'h00;
      portDir_r <= 6'h00;
    end else begin
      portOut_r <= (portOut_r & ~portEn) | (wrByte[5:0] & portEn);
      portDir_r <= (portDir_r & ~dirEn) | (wrByte[5:0] & dirEn);
    end
  end
endmodule : irs_regs
`default_nettype wire

/* File: tb/irs_regs_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the register space; one clock domain, so defaults are declared once.
module irs_regs_asserts (
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire logic [5:0] ioAddr,
  input wire logic       ioWrEn,
  input wire logic       ioRdEn,
  input wire logic [7:0] ioWrData,
  input wire logic       ioBitSetInstr,
  input wire logic       ioBitClearInstr,
  input wire logic       skipIfIoBitOne,
  input wire logic       skipIfIoBitZero,
  input wire logic [2:0] bitSel,
  input wire logic [5:0] flagSetPulse,
  input wire logic       ioRdValid_r,
  input wire logic       skipTaken_r,
  input wire logic [5:0] portOut_r,
  input wire logic [5:0] portDir_r,
  input wire logic [5:0] flagState_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Decoded request kinds, after the priority order of the access port.
  wire       noByte = !ioWrEn && !ioBitSetInstr && !ioBitClearInstr;
  wire       onlyRd = ioRdEn && noByte;
  wire       onlyT1 = skipIfIoBitOne && noByte && !ioRdEn;
  wire       anyOp  = ioWrEn || ioBitSetInstr || ioBitClearInstr || ioRdEn || skipIfIoBitOne || skipIfIoBitZero;
  wire       lowHit = ioAddr <= 6'h1F;
  wire [7:0] oneHot = 8'h01 << bitSel;
  rd_latency_a: assert property (onlyRd |-> ##2 ioRdValid_r) else $error("read answer late");
  test_one_a: assert property (onlyT1 && ioAddr == 6'h18 && bitSel < 3'h6 |-> ##2
    (ioRdValid_r && skipTaken_r == $past(portOut_r[bitSel], 2))) else $error("bit test wrong");
  high_test_a: assert property (
    (skipIfIoBitOne || skipIfIoBitZero) && noByte && !ioRdEn && !lowHit ##1 !anyOp
    |=> !ioRdValid_r) else $error("high test answered");
  port_write_a: assert property (ioWrEn && ioAddr == 6'h18 |=> portOut_r == $past(ioWrData[5:0]))
    else $error("port write lost");
  bit_set_a: assert property (ioBitSetInstr && !ioWrEn && ioAddr == 6'h18 |=>
    portOut_r == ($past(portOut_r) | $past(oneHot[5:0]))) else $error("bit set wrong");
  bit_clr_a: assert property (ioBitClearInstr && !ioWrEn && !ioBitSetInstr && ioAddr == 6'h18 |=>
    portOut_r == ($past(portOut_r) & ~$past(oneHot[5:0]))) else $error("bit clear wrong");
  // A high bit set on the watchdog flag would clear it if the range gate were broken.
  high_bit_a: assert property (
    (ioBitSetInstr || ioBitClearInstr) && !ioWrEn && !lowHit && flagSetPulse == 6'h00 |=>
    $stable(portOut_r) && $stable(portDir_r) && $stable(flagState_r)) else $error("high bit op took effect");
  flag_set_a: assert property (flagSetPulse[3] |=> flagState_r[3]) else $error("flag not set");
  flag_wone_a: assert property (
    ioBitSetInstr && !ioWrEn && ioAddr == 6'h0E && bitSel == 3'h6 && flagSetPulse == 6'h00
    |=> !flagState_r[3] && $stable({flagState_r[4], flagState_r[2]})) else $error("flag clear wrong");
  c_test: cover property (onlyT1 ##2 skipTaken_r);
  c_set: cover property (ioBitSetInstr && ioAddr == 6'h18);
  c_flag: cover property (flagState_r[3] ##1 !flagState_r[3]);
endmodule : irs_regs_asserts
bind irs_regs irs_regs_asserts u_chk (.sys_clk, .resetn, .ioAddr, .ioWrEn, .ioRdEn, .ioWrData, .ioBitSetInstr,
  .ioBitClearInstr, .skipIfIoBitOne, .skipIfIoBitZero, .bitSel, .flagSetPulse, .ioRdValid_r, .skipTaken_r,
  .portOut_r, .portDir_r, .flagState_r);
`default_nettype wire

/* File: tb/irs_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Core side of the I/O port: issues one access per call, held for exactly one taking edge.
module irs_cpu_model (
  input  wire logic       sys_clk,
  output logic [5:0]      ioAddr,
  output logic            ioWrEn,
  output logic            ioRdEn,
  output logic [7:0]      ioWrData,
  output logic            ioBitSetInstr,
  output logic            ioBitClearInstr,
  output logic            skipIfIoBitOne,
  output logic            skipIfIoBitZero,
  output logic [2:0]      bitSel
);
  initial begin
    {ioAddr, ioWrEn, ioRdEn, ioWrData, ioBitSetInstr, ioBitClearInstr, skipIfIoBitOne, skipIfIoBitZero, bitSel} = '0;
  end
  // Callers pick data with zero in reserved bits and stay off reserved addresses unless a check asks.
  task automatic req(input irs_pkg::irs_acc_t k, input logic [5:0] a, input logic [7:0] d, input logic [2:0] b);
    @(posedge sys_clk);
    ioAddr <= a;
    ioWrData <= d;
    bitSel <= b;
    ioWrEn <= (k == irs_pkg::ACC_WRITE);
    ioBitSetInstr <= (k == irs_pkg::ACC_SET);
    ioBitClearInstr <= (k == irs_pkg::ACC_CLR);
    ioRdEn <= (k == irs_pkg::ACC_READ);
    skipIfIoBitOne <= (k == irs_pkg::ACC_TEST1);
    skipIfIoBitZero <= (k == irs_pkg::ACC_TEST0);
    @(posedge sys_clk);
    // Released address and data lines show the inverse so that a stale value can never pass for a held one.
    {ioWrEn, ioRdEn, ioBitSetInstr, ioBitClearInstr, skipIfIoBitOne, skipIfIoBitZero} <= '0;
    ioAddr <= ~a;
    ioWrData <= ~d;
  endtask : req
endmodule : irs_cpu_model
`default_nettype wire

/* File: tb/irs_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module irs_regs_tb;
  logic       sys_clk, resetn, compOutLevel, serialCountLevel, pllLockLevel;
  logic [5:0] flagSetPulse, pinLevels, portOut_r, portDir_r, flagState_r;
  logic [7:0] adcResultLow, adcResultHigh, serialBufData, ioRdData_r, ioWrData, d;
  logic       ioWrEn, ioRdEn, ioBitSetInstr, ioBitClearInstr, skipIfIoBitOne, skipIfIoBitZero, ioRdValid_r, skipTaken_r;
  logic [5:0] ioAddr;
  logic [2:0] bitSel;
  logic       v, s;
  int         fail_count, samples_checked;
  // Writes of all ones and the read-back that the bit layout allows, live inputs included.
  localparam logic [5:0] TA [14] = '{6'h11, 6'h17, 6'h03, 6'h08, 6'h0E, 6'h27, 6'h09, 6'h1B, 6'h30, 6'h01, 6'h04, 6'h16,
    6'h05, 6'h10};
  localparam logic [7:0] TE [14] = '{8'hFF, 8'h3F, 8'hE7, 8'hEB, 8'h1F, 8'h87, 8'h00, 8'h00, 8'h00, 8'h00, 8'h5A, 8'h2A,
    8'h03, 8'hC3};
  irs_cpu_model u_cpu (.sys_clk, .ioAddr, .ioWrEn, .ioRdEn, .ioWrData, .ioBitSetInstr, .ioBitClearInstr,
    .skipIfIoBitOne, .skipIfIoBitZero, .bitSel);
  irs_regs u_dut (.sys_clk, .resetn, .ioAddr, .ioWrEn, .ioRdEn, .ioWrData, .ioBitSetInstr, .ioBitClearInstr,
    .skipIfIoBitOne, .skipIfIoBitZero, .bitSel, .flagSetPulse, .adcResultLow, .adcResultHigh, .serialBufData,
    .pinLevels, .compOutLevel, .serialCountLevel, .pllLockLevel, .ioRdData_r, .ioRdValid_r, .skipTaken_r,
    .portOut_r, .portDir_r, .flagState_r);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  // One read or test; the answer is awaited for a bounded number of edges.
  task automatic acc(input irs_pkg::irs_acc_t k, input logic [5:0] a, input logic [2:0] b);
    u_cpu.req(k, a, 8'h00, b);
    v = 1'b0;
    for (int i = 0; i < 3 && v !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
      v = ioRdValid_r;
    end
    d = ioRdData_r;
    s = skipTaken_r;
  endtask : acc
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    acc(irs_pkg::ACC_READ, a, 3'h0);
    if (v !== 1'b1) begin
      fail_count++;
      conclude();
    end
    check(d, exp);
  endtask : rd
  // A bit operation or byte write, then a look at the outputs once it has landed.
  task automatic op(input irs_pkg::irs_acc_t k, input logic [5:0] a, input logic [7:0] w, input logic [2:0] b);
    u_cpu.req(k, a, w, b);
    @(posedge sys_clk);
    #1;
  endtask : op
  initial begin
    {fail_count, samples_checked} = '0;
    {resetn, flagSetPulse} = '0;
    {adcResultLow, adcResultHigh, serialBufData, pinLevels} = {8'h5A, 8'h03, 8'hC3, 6'h2A};
    {compOutLevel, pllLockLevel, serialCountLevel} = 3'b111;
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(6'h18, 8'h00);
    check({2'b00, flagState_r}, 8'h00);
    // Reserved places and read-only bits are written on purpose here.
    for (int i = 0; i < 14; i++) begin
      op(irs_pkg::ACC_WRITE, TA[i], 8'hFF, 3'h0);
      rd(TA[i], TE[i]);
    end
    check({2'b00, portDir_r}, 8'h3F);
    op(irs_pkg::ACC_WRITE, 6'h18, 8'h05, 3'h0);
    op(irs_pkg::ACC_SET, 6'h18, 8'h00, 3'h4);
    check({2'b00, portOut_r}, 8'h15);
    op(irs_pkg::ACC_CLR, 6'h18, 8'h00, 3'h0);
    check({2'b00, portOut_r}, 8'h14);
    op(irs_pkg::ACC_WRITE, 6'h25, 8'h00, 3'h0);
    op(irs_pkg::ACC_SET, 6'h25, 8'h00, 3'h1);
    rd(6'h25, 8'h00);
    // Tests of a one bit and a zero bit, each way round.
    for (int i = 0; i < 4; i++) begin
      acc(i[0] ? irs_pkg::ACC_TEST0 : irs_pkg::ACC_TEST1, 6'h18, i[1] ? 3'h0 : 3'h2);
      check({6'h00, v, s}, {7'h01, i[0] ^ ~i[1]});
    end
    acc(irs_pkg::ACC_TEST1, 6'h25, 3'h0);
    check({7'h00, v}, 8'h00);
    @(posedge sys_clk);
    flagSetPulse <= 6'h3F;
    @(posedge sys_clk);
    flagSetPulse <= 6'h00;
    #1;
    check({2'b00, flagState_r}, 8'h3F);
    op(irs_pkg::ACC_SET, 6'h0E, 8'h00, 3'h6);
    check({2'b00, flagState_r}, 8'h37);
    op(irs_pkg::ACC_CLR, 6'h0E, 8'h00, 3'h7);
    check({2'b00, flagState_r}, 8'h37);
    op(irs_pkg::ACC_WRITE, 6'h06, 8'h10, 3'h0);
    check({2'b00, flagState_r}, 8'h36);
    op(irs_pkg::ACC_SET, 6'h21, 8'h00, 3'h7);
    check({2'b00, flagState_r}, 8'h36);
    rd(6'h06, 8'h00);
    rd(6'h0E, 8'hBF);
    // A reset in mid-run must bring flags, pins and storage back to zero.
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    check({2'b00, portDir_r}, 8'h00);
    check({2'b00, flagState_r}, 8'h00);
    @(posedge sys_clk);
    resetn <= 1'b1;
    rd(6'h0E, 8'h10);
    conclude();
  end
endmodule : irs_regs_tb
`default_nettype wire
